// ### hdl/timer_regs.vh
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// Register offsets on the 5-bit register select
`define OFS_CONTROL       5'h10
`define OFS_VECTOR        5'h11
`define OFS_PRELOAD_NULL  5'h12
`define OFS_PRELOAD_HIGH  5'h13
`define OFS_PRELOAD_MID   5'h14
`define OFS_PRELOAD_LOW   5'h15
`define OFS_COUNT_NULL    5'h16
`define OFS_COUNT_HIGH    5'h17
`define OFS_COUNT_MID     5'h18
`define OFS_COUNT_LOW     5'h19
`define OFS_FLAGS         5'h1a

// Control and flag field positions
`define CTL_ENABLE        0
`define CTL_CLK_LO        1
`define CTL_CLK_HI        2
`define CTL_ZD_ROLL       4
`define CTL_PIN_LO        5
`define CTL_PIN_HI        7
`define FLAG_ZERO         0

// Clock select codes
`define CLK_SYS           2'h0
`define CLK_SYS_GATED     2'h1
`define CLK_TIN_PRESC     2'h2
`define CLK_TIN_DIRECT    2'h3

// Reset and forced values
`define CONTROL_RESET     8'h00
`define VECTOR_RESET      8'h0f
`define PRESC_HALT        5'h1f
`define PRESC_ZERO        5'h00

`endif

// ### hdl/tin_sync.v
`timescale 1ns/1ps
module tin_sync (
    input  wire SYS_CLK,
    input  wire RST_N,
    input  wire PIN_IN,
    output wire LEVEL,
    output wire RISE
);
    reg stage1_ff;
    reg stage2_ff;
    reg stage3_ff;

    // Stage one is read only by stage two
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
        end else begin
            stage1_ff <= PIN_IN;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    assign LEVEL = stage2_ff;
    assign RISE  = stage2_ff & ~stage3_ff;
endmodule // tin_sync

// ### hdl/prescaled_down_timer.v
`timescale 1ns/1ps
`include "timer_regs.vh"
module prescaled_down_timer (
    input  wire       SYS_CLK,
    input  wire       RST_N,
    input  wire       CS_N,
    input  wire       READ_WRITE,
    input  wire [4:0] REG_SEL,
    input  wire [7:0] DATA_IN,
    output wire [7:0] DATA_OUT,
    output wire       DATA_OE,
    output wire       TRANSFER_ACK_N,
    input  wire       TIMER_INT_ACK_N,
    input  wire       TIMER_INPUT_PIN,
    output wire       TIMER_OUTPUT_PIN,
    output wire       TIMER_OUTPUT_OE
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ACK  = 1'b1;

    reg        state_ff;
    reg        nxt_state;
    reg [7:0]  control_ff;
    reg [7:0]  vector_ff;
    reg [7:0]  preload_high_ff;
    reg [7:0]  preload_mid_ff;
    reg [7:0]  preload_low_ff;
    reg [23:0] count_ff;
    reg [23:0] nxt_count;
    reg [4:0]  presc_ff;
    reg [4:0]  nxt_presc;
    reg        first_ff;
    reg        zero_flag_ff;
    reg        square_ff;
    reg [7:0]  rdata_ff;
    reg        drive_ff;
    reg        tick;
    reg        zero_hit;
    reg [7:0]  nxt_control;
    reg [7:0]  nxt_vector;
    reg        nxt_first;
    reg        nxt_zero_flag;
    reg        nxt_square;

    wire       tin_level;
    wire       tin_rise;
    wire [1:0] clk_sel   = control_ff[`CTL_CLK_HI:`CTL_CLK_LO];
    wire [2:0] pin_mode  = control_ff[`CTL_PIN_HI:`CTL_PIN_LO];
    wire       int_mode  = pin_mode[2] & pin_mode[0];
    wire       vect_mode = (pin_mode == 3'h5);
    wire       int_req   = int_mode & zero_flag_ff;
    wire       bus_start = (state_ff == ST_IDLE) & ~CS_N;
    wire       ack_start = (state_ff == ST_IDLE) & CS_N & ~TIMER_INT_ACK_N & vect_mode & int_req;
    wire       wr_strobe = bus_start & ~READ_WRITE;
    wire       run;
    wire       square_mode = (pin_mode[2:1] == 2'h1);
    wire       wr_control;
    wire       wr_vector;
    wire       wr_pre_high;
    wire       wr_pre_mid;
    wire       wr_pre_low;
    wire       flag_clear;

    tin_sync u_tin_sync (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .PIN_IN  (TIMER_INPUT_PIN),
        .LEVEL   (tin_level),
        .RISE    (tin_rise)
    );

    // Gated mode needs the input high as well as the enable bit
    assign run = control_ff[`CTL_ENABLE] &
                 ((clk_sel != `CLK_SYS_GATED) | tin_level);

    function wr_hit;
        input       strobe;
        input [4:0] sel;
        input [4:0] ofs;
        begin
            wr_hit = strobe & (sel == ofs);
        end
    endfunction

    // Bit 3 of control is unused: never stored, always reads zero
    function [7:0] ctl_mask;
        input [7:0] value;
        begin
            ctl_mask = {value[7:4], 1'b0, value[2:0]};
        end
    endfunction

    function [23:0] join_bytes;
        input [7:0] high;
        input [7:0] mid;
        input [7:0] low;
        begin
            join_bytes = {high, mid, low};
        end
    endfunction

    assign wr_control  = wr_hit(wr_strobe, REG_SEL, `OFS_CONTROL);
    assign wr_vector   = wr_hit(wr_strobe, REG_SEL, `OFS_VECTOR);
    assign wr_pre_high = wr_hit(wr_strobe, REG_SEL, `OFS_PRELOAD_HIGH);
    assign wr_pre_mid  = wr_hit(wr_strobe, REG_SEL, `OFS_PRELOAD_MID);
    assign wr_pre_low  = wr_hit(wr_strobe, REG_SEL, `OFS_PRELOAD_LOW);
    assign flag_clear  = wr_hit(wr_strobe, REG_SEL, `OFS_FLAGS) & DATA_IN[`FLAG_ZERO];

    function [7:0] read_mux;
        input [4:0] ofs;
        begin
            case (ofs)
                `OFS_CONTROL:      read_mux = ctl_mask(control_ff);
                `OFS_VECTOR:       read_mux = vector_ff;
                `OFS_PRELOAD_NULL: read_mux = 8'h00;
                `OFS_PRELOAD_HIGH: read_mux = preload_high_ff;
                `OFS_PRELOAD_MID:  read_mux = preload_mid_ff;
                `OFS_PRELOAD_LOW:  read_mux = preload_low_ff;
                `OFS_COUNT_NULL:   read_mux = 8'h00;
                `OFS_COUNT_HIGH:   read_mux = count_ff[23:16];
                `OFS_COUNT_MID:    read_mux = count_ff[15:8];
                `OFS_COUNT_LOW:    read_mux = count_ff[7:0];
                `OFS_FLAGS:        read_mux = {7'h00, zero_flag_ff};
                default:           read_mux = 8'h00;
            endcase
        end
    endfunction

    // Bus cycle: take the access once, hold acknowledge until strobe goes away
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (bus_start | ack_start) begin
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK: begin
                if (CS_N & TIMER_INT_ACK_N) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
            rdata_ff <= 8'h00;
            drive_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (ack_start) begin
                rdata_ff <= vector_ff;
                drive_ff <= 1'b1;
            end else if (bus_start) begin
                rdata_ff <= read_mux(REG_SEL);
                drive_ff <= READ_WRITE;
            end else if (nxt_state == ST_IDLE) begin
                drive_ff <= 1'b0;
            end
        end
    end

    assign DATA_OUT       = rdata_ff;
    assign DATA_OE        = drive_ff;
    assign TRANSFER_ACK_N = ~(state_ff == ST_ACK);

    always @* begin
        nxt_control = control_ff;
        nxt_vector  = vector_ff;
        if (wr_control) begin
            nxt_control = ctl_mask(DATA_IN);
        end
        if (wr_vector) begin
            nxt_vector = DATA_IN;
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            control_ff <= `CONTROL_RESET;
            vector_ff  <= `VECTOR_RESET;
        end else begin
            control_ff <= nxt_control;
            vector_ff  <= nxt_vector;
        end
    end

    // No reset here: preload bytes survive reset
    always @(posedge SYS_CLK) begin
        if (wr_pre_high) begin
            preload_high_ff <= DATA_IN;
        end
        if (wr_pre_mid) begin
            preload_mid_ff <= DATA_IN;
        end
        if (wr_pre_low) begin
            preload_low_ff <= DATA_IN;
        end
    end

    // Counter clock source and prescaler
    always @* begin
        nxt_presc = presc_ff;
        tick      = 1'b0;
        if (!run) begin
            nxt_presc = `PRESC_HALT;
        end else if (clk_sel == `CLK_TIN_DIRECT) begin
            tick = tin_rise;
        end else if ((clk_sel != `CLK_TIN_PRESC) | tin_rise) begin
            nxt_presc = presc_ff - 5'h01;
            tick      = (presc_ff == `PRESC_ZERO);
        end
    end

    // Load on first tick, then decrement, reload or roll over
    always @* begin
        nxt_count = count_ff;
        zero_hit  = 1'b0;
        if (tick) begin
            if (first_ff) begin
                nxt_count = join_bytes(preload_high_ff, preload_mid_ff, preload_low_ff);
            end else if ((count_ff == 24'h000000) & ~control_ff[`CTL_ZD_ROLL]) begin
                nxt_count = join_bytes(preload_high_ff, preload_mid_ff, preload_low_ff);
            end else begin
                nxt_count = count_ff - 24'h000001;
                zero_hit  = (count_ff == 24'h000001);
            end
        end
    end

    always @(posedge SYS_CLK) begin
        count_ff <= nxt_count;
    end

    // Flag, square wave, first-tick marker; set beats a same-cycle clear
    always @* begin
        nxt_first     = first_ff;
        nxt_zero_flag = zero_flag_ff;
        nxt_square    = square_ff;
        if (!run) begin
            nxt_first     = 1'b1;
            nxt_zero_flag = 1'b0;
            nxt_square    = 1'b1;
        end else begin
            if (tick) begin
                nxt_first = 1'b0;
            end
            if (zero_hit) begin
                nxt_zero_flag = 1'b1;
                nxt_square    = ~square_ff;
            end else if (flag_clear) begin
                nxt_zero_flag = 1'b0;
            end
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            presc_ff     <= `PRESC_HALT;
            first_ff     <= 1'b1;
            zero_flag_ff <= 1'b0;
            square_ff    <= 1'b1;
        end else begin
            presc_ff     <= nxt_presc;
            first_ff     <= nxt_first;
            zero_flag_ff <= nxt_zero_flag;
            square_ff    <= nxt_square;
        end
    end

    // Pin use: port input, square wave, or open-drain request
    assign TIMER_OUTPUT_PIN = square_mode ? square_ff : 1'b0;
    assign TIMER_OUTPUT_OE  = square_mode | int_req;
    // Rate limit on the counter clock is the system's to keep
endmodule // prescaled_down_timer

// ### testbench/prescaled_down_timer_properties.sv
`timescale 1ns/1ps
`include "timer_regs.vh"
module timer_bus_properties (
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    input wire logic       CS_N,
    input wire logic       READ_WRITE,
    input wire logic [4:0] REG_SEL,
    input wire logic [7:0] DATA_OUT,
    input wire logic       DATA_OE,
    input wire logic       TRANSFER_ACK_N,
    input wire logic       TIMER_INT_ACK_N,
    input wire logic       TIMER_OUTPUT_OE
);
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_go; $fell(CS_N) && TRANSFER_ACK_N; endsequence
    sequence s_held; !TRANSFER_ACK_N && !(CS_N && TIMER_INT_ACK_N); endsequence
    property p_ack; s_go |=> !TRANSFER_ACK_N; endproperty
    a_ack: assert property (p_ack) else $error("late ack");
    property p_stand; s_held |=> !TRANSFER_ACK_N; endproperty
    a_stand: assert property (p_stand) else $error("ack dropped early");
    property p_free;
        !TRANSFER_ACK_N && CS_N && TIMER_INT_ACK_N |-> ##[1:2] TRANSFER_ACK_N;
    endproperty
    a_free: assert property (p_free) else $error("ack not released");
    property p_hold; s_held ##1 !TRANSFER_ACK_N |-> $stable(DATA_OUT); endproperty
    a_hold: assert property (p_hold) else $error("data moved in cycle");
    property p_quiet; s_go ##0 !READ_WRITE |=> !DATA_OE; endproperty
    a_quiet: assert property (p_quiet) else $error("drive on write");
    property p_pnull; s_go ##0 (READ_WRITE && REG_SEL == `OFS_PRELOAD_NULL) |=> DATA_OUT == 8'h00;
    endproperty
    a_pnull: assert property (p_pnull) else $error("preload pad not zero");
    property p_cnull; s_go ##0 (READ_WRITE && REG_SEL == `OFS_COUNT_NULL) |=> DATA_OUT == 8'h00;
    endproperty
    a_cnull: assert property (p_cnull) else $error("count pad not zero");
    property p_noresp;
        $fell(TIMER_INT_ACK_N) && CS_N && TRANSFER_ACK_N && !TIMER_OUTPUT_OE |=> TRANSFER_ACK_N;
    endproperty
    a_noresp: assert property (p_noresp) else $error("ack without request");
endmodule // timer_bus_properties
bind prescaled_down_timer timer_bus_properties u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .CS_N(CS_N), .READ_WRITE(READ_WRITE), .REG_SEL(REG_SEL), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .TRANSFER_ACK_N(TRANSFER_ACK_N), .TIMER_INT_ACK_N(TIMER_INT_ACK_N),
    .TIMER_OUTPUT_OE(TIMER_OUTPUT_OE));

// ### testbench/bus_host.sv
`timescale 1ns/1ps
module bus_host (
    input  wire logic       SYS_CLK,
    input  wire logic       TRANSFER_ACK_N,
    input  wire logic [7:0] DATA_OUT,
    output logic            CS_N,
    output logic            READ_WRITE,
    output logic [4:0]      REG_SEL,
    output logic [7:0]      DATA_IN,
    output logic            TIMER_INT_ACK_N
);
    initial begin
        CS_N = 1'b1;
        READ_WRITE = 1'b1;
        REG_SEL = 5'h00;
        DATA_IN = 8'h00;
        TIMER_INT_ACK_N = 1'b1;
    end
    // Strobes held until the ack is sampled, then idle seen before return
    task automatic cycle(input logic ia, input logic rw, input logic [4:0] a,
                         input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        @(posedge SYS_CLK);
        CS_N <= ia;
        TIMER_INT_ACK_N <= !ia;
        READ_WRITE <= rw;
        REG_SEL <= a;
        DATA_IN <= d;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (TRANSFER_ACK_N !== 1'b0 && n < 8);
        ok = (TRANSFER_ACK_N === 1'b0);
        q = DATA_OUT;
        CS_N <= 1'b1;
        TIMER_INT_ACK_N <= 1'b1;
        DATA_IN <= ~d;
        while (TRANSFER_ACK_N !== 1'b1 && n < 16) begin
            @(posedge SYS_CLK);
            n++;
        end
    endtask
endmodule // bus_host

// ### testbench/prescaled_down_timer_tb_top.sv
`timescale 1ns/1ps
`include "timer_regs.vh"
module prescaled_down_timer_tb_top;
    logic       sys_clk;
    logic       rst_n;
    logic       tin;
    logic [7:0] rd;
    logic [7:0] keep;
    logic       ok;
    int         errors = 0;
    int         n_compared = 0;
    wire        cs_n, rw, ack_n, iack_n, timer_output_pin, timer_output_pin_oe;
    wire  [4:0] sel;
    wire  [7:0] din, dout;
    prescaled_down_timer dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .READ_WRITE(rw),
        .REG_SEL(sel), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(), .TRANSFER_ACK_N(ack_n),
        .TIMER_INT_ACK_N(iack_n), .TIMER_INPUT_PIN(tin), .TIMER_OUTPUT_PIN(timer_output_pin),
        .TIMER_OUTPUT_OE(timer_output_pin_oe));
    bus_host host (.SYS_CLK(sys_clk), .TRANSFER_ACK_N(ack_n), .DATA_OUT(dout), .CS_N(cs_n),
        .READ_WRITE(rw), .REG_SEL(sel), .DATA_IN(din), .TIMER_INT_ACK_N(iack_n));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.cycle(1'b0, 1'b0, a, d, rd, ok);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        host.cycle(1'b0, 1'b1, a, 8'h00, rd, ok);
        check(rd, e);
    endtask
    task automatic flg(input logic e);
        host.cycle(1'b0, 1'b1, `OFS_FLAGS, 8'h00, rd, ok);
        check({7'h00, rd[0]}, {7'h00, e});
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            tin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            tin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        tin = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(`OFS_CONTROL, 8'h00);
        rdc(`OFS_VECTOR, 8'h0f);
        wr(`OFS_VECTOR, 8'ha5);
        wr(`OFS_PRELOAD_NULL, 8'hff);
        wr(`OFS_COUNT_NULL, 8'hff);
        rdc(`OFS_VECTOR, 8'ha5);
        rdc(`OFS_PRELOAD_NULL, 8'h00);
        rdc(`OFS_COUNT_NULL, 8'h00);
        wr(`OFS_PRELOAD_HIGH, 8'h00);
        wr(`OFS_PRELOAD_MID, 8'h00);
        wr(`OFS_PRELOAD_LOW, 8'h02);
        rdc(`OFS_PRELOAD_LOW, 8'h02);
        wr(`OFS_CONTROL, 8'ha1);
        for (int i = 0; i < 40 && rd[0] !== 1'b1; i++)
            host.cycle(1'b0, 1'b1, `OFS_FLAGS, 8'h00, rd, ok);
        flg(1'b1);
        check({6'h00, timer_output_pin_oe, timer_output_pin}, 8'h02);
        host.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
        check(ok ? rd : 8'h00, 8'ha5);
        wr(`OFS_FLAGS, 8'h01);
        flg(1'b0);
        check({7'h00, timer_output_pin_oe}, 8'h00);
        host.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
        check({7'h00, ok}, 8'h00);
        wr(`OFS_CONTROL, 8'ha0);
        host.cycle(1'b0, 1'b1, `OFS_COUNT_LOW, 8'h00, keep, ok);
        wr(`OFS_COUNT_LOW, 8'h55);
        rdc(`OFS_COUNT_LOW, keep);
        rdc(`OFS_COUNT_HIGH, 8'h00);
        wr(`OFS_PRELOAD_LOW, 8'h03);
        wr(`OFS_CONTROL, 8'h47);
        check({6'h00, timer_output_pin_oe, timer_output_pin}, 8'h03);
        pulses(4);
        flg(1'b1);
        check({6'h00, timer_output_pin_oe, timer_output_pin}, 8'h02);
        rdc(`OFS_COUNT_LOW, 8'h00);
        wr(`OFS_CONTROL, 8'h06);
        flg(1'b0);
        wr(`OFS_PRELOAD_LOW, 8'h01);
        wr(`OFS_CONTROL, 8'h17);
        pulses(3);
        rdc(`OFS_COUNT_HIGH, 8'hff);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(`OFS_COUNT_HIGH, 8'hff);
        rdc(`OFS_PRELOAD_LOW, 8'h01);
        rdc(`OFS_CONTROL, 8'h00);
        rdc(`OFS_VECTOR, 8'h0f);
        flg(1'b0);
        wr(`OFS_CONTROL, 8'h13);
        pulses(4);
        rdc(`OFS_COUNT_LOW, 8'hff);
        wr(`OFS_CONTROL, 8'h15);
        pulses(64);
        flg(1'b1);
        end_of_test();
    end
endmodule // prescaled_down_timer_tb_top
